// >>> core/blc_map.vh
// Constants shared by the burst loop line codec core and its helpers
// Assumes one 250 MHz core clock; all slower rates come from dividers
// Operation
// - Ones leave as alternating-polarity pulses; zeros leave as no pulse
// - Full-duplex traffic moves as alternating compressed bursts on one pair
// - Master owns loop timing; a serial control bit picks master or slave
// - All activation and deactivation timing is generated inside the block
// - After reset the block sits powered down with outputs idle
// - Control bits reset to zero, so the block starts as master
// - Setting the activate bit powers up the block and starts activation
// - Clearing the activate bit deactivates and powers down, detector kept
// - Master bursts follow burst sync if present, else frame sync A
// - The line signal detector keeps watching the line while powered down
// - Every sent bit but the start bit passes the x9+x5+1 scrambler
// - Received symbols are descrambled with the same polynomial
// - The receive phase tracker derives sampling from the reference rate
// - Master transmits on the reference; tracker only samples receive data
// - Slave runs both transmit and receive from the phase tracker
// - Bit timing acquires in about 25 ms, burst sync about 50 ms
// - Status alert latches low on a loop sync or line detector change, clears on status read
// - Control port acts only while select is low
// - Each burst opens with an unscrambled one of opposite polarity
// - Slave stops receiving after 36 bits, waits 6 symbols, then sends
// - Four empty expected receive windows in a row drop loop sync
// - Transfer swaps one byte each way in 8 clocks, in rising, out falling
`ifndef BLC_MAP_VH
`define BLC_MAP_VH

// ==========================================
// Timing
`define BLC_CLK_HZ 250000000
`define BLC_CLK_KHZ 250000
`define BLC_SYM_KBAUD 256
`define BLC_BURST_HZ 4000
`define BLC_ACQ_MS 25
`define BLC_SYNC_MS 50

// ==========================================
// Burst format and flywheel
`define BLC_BURST_BITS 6'd36
`define BLC_GUARD_SYMS 6'd6
`define BLC_FLY_COUNT 3'd4

// ==========================================
// Control and status bits
`define BLC_CTRL_BITS 3'd7
`define BLC_CR_SLAVE 7
`define BLC_CR_ACT 6
`define BLC_CR_RESET 8'h00
`define BLC_SR_LSD 0
`define BLC_SR_SYNC 1
`define BLC_SR_BPV 2
`define BLC_SR_LATE 3

// ==========================================
// Scrambler
`define BLC_SCR_LEN 9
`define BLC_SCR_TAP 5

`endif

// >>> core/blc_scram.v
// Self-synchronising scrambler or descrambler, one bit per enable
// Assumes enable pulses at the symbol rate from the core
`timescale 1ns/10ps
`include "blc_map.vh"

module blc_scram #(
    parameter DESCR = 0,
    parameter LEN = `BLC_SCR_LEN,
    parameter TAP = `BLC_SCR_TAP
) (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Bit stream
    input wire en,
    input wire din,
    output wire dout
);

reg [LEN-1:0] sr_r;
wire fb;
wire shin;

// ==========================================
// Feedback x^LEN + x^TAP + 1
assign fb = sr_r[LEN-1] ^ sr_r[TAP-1];
assign dout = din ^ fb;
// Descrambler shifts line bits so it resyncs after errors
assign shin = DESCR ? din : dout;

always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
        sr_r <= {LEN{1'b0}};
    else if (en)
        sr_r <= {sr_r[LEN-2:0], shin};
end

endmodule // blc_scram

// >>> core/blc_fifo.v
// Flip-flop FIFO with valid/ready on both sides
// Assumes one clock; depth is a power of two of 2**AW
`timescale 1ns/10ps

module blc_fifo #(
    parameter W = 1,
    parameter AW = 4
) (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Fill side
    input wire in_valid,
    output wire in_ready,
    input wire [W-1:0] in_data,
    // Drain side
    output wire out_valid,
    input wire out_ready,
    output wire [W-1:0] out_data
);

reg [W-1:0] mem_r [0:(1<<AW)-1];
reg [AW:0] wp_r;
reg [AW:0] rp_r;
wire push;
wire pop;

// ==========================================
// Flags
assign out_valid = wp_r != rp_r;
assign in_ready = !((wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]));
assign out_data = mem_r[rp_r[AW-1:0]];
assign push = in_valid & in_ready;
assign pop = out_valid & out_ready;

always @(posedge clk)
begin
    if (push)
        mem_r[wp_r[AW-1:0]] <= in_data;
end

always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        wp_r <= {(AW+1){1'b0}};
        rp_r <= {(AW+1){1'b0}};
    end
    else
    begin
        if (push)
            wp_r <= wp_r + 1'b1;
        if (pop)
            rp_r <= rp_r + 1'b1;
    end
end

endmodule // blc_fifo

// >>> core/blc_core.v
// Burst loop line codec core: control port, burst timing, AMI, scrambling
// Assumes all pins are synchronous to CORE_CLK; line pins carry symbols
`timescale 1ns/10ps
`include "blc_map.vh"

module blc_core #(
    parameter SYM_CYC = `BLC_CLK_KHZ / `BLC_SYM_KBAUD,
    parameter BURST_CYC = `BLC_CLK_HZ / `BLC_BURST_HZ,
    parameter ACQ_CYC = `BLC_CLK_KHZ * `BLC_ACQ_MS,
    parameter SYNC_CYC = `BLC_CLK_KHZ * `BLC_SYNC_MS,
    parameter FIFO_AW = 4
) (
    // Clock and reset
    input wire CORE_CLK,
    input wire NRST,
    // Serial control port
    input wire CTRL_SHIFT_CLOCK,
    input wire CTRL_SEL_N,
    input wire CTRL_SERIAL_IN,
    output reg CTRL_SERIAL_OUT,
    output wire CTRL_SERIAL_OE,
    // Open-drain status alert
    output wire STATUS_ALERT_N,
    output wire STATUS_ALERT_OE,
    // Burst timing
    input wire BURST_SYNC_INPUT,
    input wire FRAME_SYNC_A,
    // Line symbols
    output reg LINE_TX_POS,
    output reg LINE_TX_NEG,
    input wire LINE_RX_POS,
    input wire LINE_RX_NEG,
    output wire LINE_SIGNAL_DETECTOR_N,
    // Bearer data
    input wire TX_DATA,
    input wire TX_VALID,
    output wire TX_READY,
    output reg RX_DATA,
    output reg RX_VALID,
    // Status
    output wire POWERED_UP,
    output wire LOOP_SYNC
);

localparam ST_OFF = 3'd0;
localparam ST_WAIT = 3'd1;
localparam ST_TX = 3'd2;
localparam ST_GUARD = 3'd3;
localparam ST_RX = 3'd4;
localparam [9:0] SYM_LAST = SYM_CYC[9:0] - 10'd1;
localparam [9:0] SYM_HALF = SYM_CYC[10:1];
localparam [16:0] BURST_LAST = BURST_CYC[16:0] - 17'd1;
localparam [17:0] AGE_LIM = {BURST_CYC[16:0], 1'b0};
localparam [23:0] ACQ_LIM = ACQ_CYC[23:0];
localparam [23:0] SYNC_LIM = SYNC_CYC[23:0];

reg [7:0] ctrl_r;
reg [7:0] sin_r;
reg [7:0] sout_r;
reg [2:0] bit_cnt_r;
reg ctrl_shift_clock_d_r;
reg sel_d_r;
reg alert_r;
reg bpv_r;
reg late_r;
reg [2:0] st_r;
reg [2:0] st_nxt;
reg [5:0] sym_r;
reg [9:0] ref_cnt_r;
reg [9:0] trk_cnt_r;
reg [16:0] btmr_r;
reg [17:0] mbs_age_r;
reg [17:0] lsd_age_r;
reg [23:0] acq_cnt_r;
reg mbs_d_r;
reg fsa_d_r;
reg fsa_half_r;
reg mark_d_r;
reg wake_alt_r;
reg rx_on_r;
reg tx_pol_r;
reg rx_pol_r;
reg sync_r;
reg sync_d_r;
reg lsd_d_r;
reg [2:0] good_r;
reg [2:0] miss_r;
wire slave;
wire pwr;
wire ctrl_shift_clock_rise;
wire ctrl_shift_clock_fall;
wire sel_rise;
wire sel_fall;
wire [7:0] status;
wire ref_tick;
wire trk_tick;
wire tx_tick;
wire btmr_tick;
wire mbs_rise;
wire mbs_present;
wire fsa_tick;
wire master_tick;
wire rx_mark;
wire mark_rise;
wire line_signal_detector;
wire acq_done;
wire smp;
wire last_bit;
wire burst_good;
wire burst_miss;
wire tx_bit;
wire tx_scr;
wire tx_mark;
wire fifo_valid;
wire fifo_data;
wire fifo_pop;
wire rx_dscr;

assign slave = ctrl_r[`BLC_CR_SLAVE];
assign pwr = ctrl_r[`BLC_CR_ACT];
assign POWERED_UP = pwr;
assign LOOP_SYNC = sync_r;

// ==========================================
// Serial control port
assign ctrl_shift_clock_rise = CTRL_SHIFT_CLOCK & ~ctrl_shift_clock_d_r;
assign ctrl_shift_clock_fall = ~CTRL_SHIFT_CLOCK & ctrl_shift_clock_d_r;
assign sel_fall = ~CTRL_SEL_N & sel_d_r;
assign sel_rise = CTRL_SEL_N & ~sel_d_r;
assign status = {ctrl_r[7:6], 2'b00, late_r, bpv_r, sync_r, line_signal_detector};
assign CTRL_SERIAL_OE = ~CTRL_SEL_N;

always @(posedge CORE_CLK or negedge NRST)
begin
    if (!NRST)
    begin
        ctrl_r <= `BLC_CR_RESET;
        sin_r <= 8'h00;
        sout_r <= 8'h00;
        bit_cnt_r <= 3'h0;
        ctrl_shift_clock_d_r <= 1'b0;
        sel_d_r <= 1'b1;
        CTRL_SERIAL_OUT <= 1'b0;
    end
    else
    begin
        ctrl_shift_clock_d_r <= CTRL_SHIFT_CLOCK;
        sel_d_r <= CTRL_SEL_N;
        if (sel_fall)
        begin
            sout_r <= status;
            CTRL_SERIAL_OUT <= status[7];
            bit_cnt_r <= 3'h0;
        end
        else if (!CTRL_SEL_N && ctrl_shift_clock_rise)
        begin
            sin_r <= {sin_r[6:0], CTRL_SERIAL_IN};
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (bit_cnt_r == `BLC_CTRL_BITS)
                ctrl_r <= {sin_r[6:0], CTRL_SERIAL_IN};
        end
        else if (!CTRL_SEL_N && ctrl_shift_clock_fall && bit_cnt_r != 3'h0)
        begin
            sout_r <= {sout_r[6:0], 1'b0};
            CTRL_SERIAL_OUT <= sout_r[6];
        end
    end
end

// ==========================================
// Status alert and status flags
// A status change in the clearing cycle still wins and keeps the alert
assign STATUS_ALERT_N = 1'b0;
assign STATUS_ALERT_OE = alert_r;

always @(posedge CORE_CLK or negedge NRST)
begin
    if (!NRST)
    begin
        alert_r <= 1'b0;
        bpv_r <= 1'b0;
        sync_d_r <= 1'b0;
        lsd_d_r <= 1'b0;
    end
    else
    begin
        sync_d_r <= sync_r;
        lsd_d_r <= line_signal_detector;
        if ((sync_r != sync_d_r) || (line_signal_detector != lsd_d_r))
            alert_r <= 1'b1;
        else if (!CTRL_SEL_N && ctrl_shift_clock_rise && bit_cnt_r == 3'h0)
            alert_r <= 1'b0;
        if (smp && rx_mark && (LINE_RX_NEG == rx_pol_r))
            bpv_r <= 1'b1;
        else if (sel_rise)
            bpv_r <= 1'b0;
    end
end

// ==========================================
// Reference divider, phase tracker, burst sources
assign ref_tick = ref_cnt_r == SYM_LAST;
assign trk_tick = trk_cnt_r == SYM_LAST;
assign tx_tick = slave ? trk_tick : ref_tick;
assign btmr_tick = btmr_r == BURST_LAST;
assign rx_mark = LINE_RX_POS | LINE_RX_NEG;
assign mark_rise = rx_mark & ~mark_d_r;
assign mbs_rise = BURST_SYNC_INPUT & ~mbs_d_r;
assign mbs_present = mbs_age_r < AGE_LIM;
// Frame sync A runs at twice the burst rate, so every other edge counts
assign fsa_tick = FRAME_SYNC_A & ~fsa_d_r & fsa_half_r;
assign master_tick = mbs_present ? mbs_rise : fsa_tick;
assign line_signal_detector = lsd_age_r < AGE_LIM;
assign LINE_SIGNAL_DETECTOR_N = ~line_signal_detector;
assign acq_done = acq_cnt_r >= ACQ_LIM;

always @(posedge CORE_CLK or negedge NRST)
begin
    if (!NRST)
    begin
        ref_cnt_r <= 10'h000;
        trk_cnt_r <= 10'h000;
        btmr_r <= 17'h00000;
        mbs_age_r <= 18'h3ffff;
        lsd_age_r <= 18'h3ffff;
        acq_cnt_r <= 24'h000000;
        mbs_d_r <= 1'b0;
        fsa_d_r <= 1'b0;
        fsa_half_r <= 1'b0;
        mark_d_r <= 1'b0;
        late_r <= 1'b0;
    end
    else
    begin
        mbs_d_r <= BURST_SYNC_INPUT;
        fsa_d_r <= FRAME_SYNC_A;
        mark_d_r <= rx_mark;
        ref_cnt_r <= ref_tick ? 10'h000 : ref_cnt_r + 10'h001;
        // Pulse edges pull the sample point to mid-symbol
        if (mark_rise)
            trk_cnt_r <= SYM_HALF;
        else
            trk_cnt_r <= trk_tick ? 10'h000 : trk_cnt_r + 10'h001;
        if (burst_good || btmr_tick)
            btmr_r <= 17'h00000;
        else
            btmr_r <= btmr_r + 17'h00001;
        if (FRAME_SYNC_A && !fsa_d_r)
            fsa_half_r <= ~fsa_half_r;
        if (mbs_rise)
            mbs_age_r <= 18'h00000;
        else if (mbs_present)
            mbs_age_r <= mbs_age_r + 18'h00001;
        if (mark_rise)
            lsd_age_r <= 18'h00000;
        else if (line_signal_detector)
            lsd_age_r <= lsd_age_r + 18'h00001;
        if (!pwr)
            acq_cnt_r <= 24'h000000;
        else if (acq_cnt_r < SYNC_LIM)
            acq_cnt_r <= acq_cnt_r + 24'h000001;
        // Flags activation that has not synced in the expected time
        late_r <= pwr && !sync_r && (acq_cnt_r >= SYNC_LIM);
    end
end

// ==========================================
// Burst sequencer
assign smp = trk_tick & acq_done;
assign last_bit = sym_r == (`BLC_BURST_BITS - 6'd1);
assign burst_good = (st_r == ST_RX) && rx_on_r && smp && last_bit;
assign burst_miss = ((st_r == ST_RX) && !slave && master_tick) ||
                    ((st_r == ST_WAIT) && slave && btmr_tick && acq_done);

always @*
begin
    st_nxt = st_r;
    case (st_r)
        ST_OFF:
            if (pwr)
                st_nxt = ST_WAIT;
        ST_WAIT:
            if (!slave && master_tick)
                st_nxt = ST_TX;
            else if (slave && smp && rx_mark)
                st_nxt = ST_RX;
            else if (slave && !sync_r && btmr_tick && wake_alt_r)
                st_nxt = ST_TX;
        ST_TX:
            if (tx_tick && sym_r == `BLC_BURST_BITS)
                st_nxt = slave ? ST_WAIT : ST_RX;
        ST_GUARD:
            if (tx_tick && sym_r == `BLC_GUARD_SYMS - 6'd1)
                st_nxt = ST_TX;
        ST_RX:
            if (burst_good)
                st_nxt = slave ? ST_GUARD : ST_WAIT;
            else if (!slave && master_tick)
                st_nxt = ST_TX;
        default:
            st_nxt = ST_OFF;
    endcase
    if (!pwr)
        st_nxt = ST_OFF;
end

always @(posedge CORE_CLK or negedge NRST)
begin
    if (!NRST)
    begin
        st_r <= ST_OFF;
        sym_r <= 6'h00;
        rx_on_r <= 1'b0;
        wake_alt_r <= 1'b0;
        good_r <= 3'h0;
        miss_r <= 3'h0;
        sync_r <= 1'b0;
    end
    else
    begin
        st_r <= st_nxt;
        if (st_nxt != st_r)
            sym_r <= 6'h00;
        else if ((st_r == ST_TX || st_r == ST_GUARD) && tx_tick)
            sym_r <= sym_r + 6'h01;
        else if (st_r == ST_RX && rx_on_r && smp)
            sym_r <= sym_r + 6'h01;
        // Slave lands in receive already past the start bit
        if (st_nxt == ST_RX)
            rx_on_r <= (st_r == ST_RX) ? (rx_on_r | (smp & rx_mark)) : slave;
        else
            rx_on_r <= 1'b0;
        if (btmr_tick)
            wake_alt_r <= ~wake_alt_r;
        if (!pwr)
        begin
            good_r <= 3'h0;
            miss_r <= 3'h0;
            sync_r <= 1'b0;
        end
        else if (burst_good)
        begin
            miss_r <= 3'h0;
            if (good_r != `BLC_FLY_COUNT)
                good_r <= good_r + 3'h1;
            if (good_r == `BLC_FLY_COUNT - 3'h1)
                sync_r <= 1'b1;
        end
        else if (burst_miss)
        begin
            good_r <= 3'h0;
            if (miss_r != `BLC_FLY_COUNT)
                miss_r <= miss_r + 3'h1;
            if (miss_r == `BLC_FLY_COUNT - 3'h1)
                sync_r <= 1'b0;
        end
    end
end

// ==========================================
// Transmit path: FIFO, scrambler, AMI
// Bearer data flows only once synced; until then scrambled ones go out
assign fifo_pop = (st_r == ST_TX) && tx_tick && (sym_r != 6'h00) && sync_r;
assign tx_bit = (sync_r && fifo_valid) ? fifo_data : 1'b1;
assign tx_mark = (sym_r == 6'h00) ? 1'b1 : tx_scr;

blc_fifo #(
    .W(1),
    .AW(FIFO_AW)
) u_fifo (
    .clk(CORE_CLK),
    .rst_n(NRST),
    .in_valid(TX_VALID),
    .in_ready(TX_READY),
    .in_data(TX_DATA),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
);

blc_scram #(
    .DESCR(0)
) u_scr (
    .clk(CORE_CLK),
    .rst_n(NRST),
    .en((st_r == ST_TX) && tx_tick && (sym_r != 6'h00)),
    .din(tx_bit),
    .dout(tx_scr)
);

always @(posedge CORE_CLK or negedge NRST)
begin
    if (!NRST)
    begin
        LINE_TX_POS <= 1'b0;
        LINE_TX_NEG <= 1'b0;
        tx_pol_r <= 1'b0;
    end
    else if (tx_tick)
    begin
        // Symbols change only on ticks, so the last one of a burst stands a full period
        LINE_TX_POS <= (st_r == ST_TX) & tx_mark & ~tx_pol_r;
        LINE_TX_NEG <= (st_r == ST_TX) & tx_mark & tx_pol_r;
        if ((st_r == ST_TX) && tx_mark)
            tx_pol_r <= ~tx_pol_r;
    end
end

// ==========================================
// Receive path: descrambler and data out
blc_scram #(
    .DESCR(1)
) u_dscr (
    .clk(CORE_CLK),
    .rst_n(NRST),
    .en((st_r == ST_RX) && rx_on_r && smp),
    .din(rx_mark),
    .dout(rx_dscr)
);

always @(posedge CORE_CLK or negedge NRST)
begin
    if (!NRST)
    begin
        RX_DATA <= 1'b0;
        RX_VALID <= 1'b0;
        // Idles as after a negative mark, like the transmitter
        rx_pol_r <= 1'b1;
    end
    else
    begin
        RX_VALID <= (st_r == ST_RX) && rx_on_r && smp && sync_r;
        if ((st_r == ST_RX) && rx_on_r && smp)
            RX_DATA <= rx_dscr;
        if (smp && rx_mark)
            rx_pol_r <= LINE_RX_NEG;
    end
end

endmodule // blc_core

// >>> sim/blc_core_assertions.sv
// Port checks for the burst loop line codec core
// Assumes a bind onto blc_core with its symbol period handed on
`timescale 1ns/10ps

module blc_core_assertions #(
    parameter SYM_CYC = 8
) (
    // Clock and reset
    input wire CORE_CLK,
    input wire NRST,
    // Control port
    input wire CTRL_SHIFT_CLOCK,
    input wire CTRL_SEL_N,
    input wire CTRL_SERIAL_OE,
    input wire STATUS_ALERT_OE,
    // Line and status
    input wire LINE_TX_POS,
    input wire LINE_TX_NEG,
    input wire LINE_RX_POS,
    input wire LINE_RX_NEG,
    input wire LINE_SIGNAL_DETECTOR_N,
    input wire RX_VALID,
    input wire POWERED_UP,
    input wire LOOP_SYNC
);
    // ==========================================
    // Helpers
    // Polarity memory restarts at power-down, so the first mark of a session is free
    reg [15:0] hp_r;
    reg [15:0] hn_r;
    reg [5:0] pd_r;
    reg pol_r;
    reg seen_r;
    reg rd1_r;
    always @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            hp_r <= 16'h0000;
            hn_r <= 16'h0000;
            pd_r <= 6'h00;
            pol_r <= 1'b0;
            seen_r <= 1'b0;
            rd1_r <= 1'b1;
        end
        else
        begin
            hp_r <= LINE_TX_POS ? hp_r + 16'h0001 : 16'h0000;
            hn_r <= LINE_TX_NEG ? hn_r + 16'h0001 : 16'h0000;
            pd_r <= POWERED_UP ? 6'h00 : ((pd_r == 6'h3f) ? pd_r : pd_r + 6'h01);
            // High until the first shift-clock rise of a transfer, the status read
            rd1_r <= CTRL_SEL_N | (rd1_r & !$rose(CTRL_SHIFT_CLOCK));
            if (!POWERED_UP)
                seen_r <= 1'b0;
            else if ($rose(LINE_TX_POS) || $rose(LINE_TX_NEG))
                seen_r <= 1'b1;
            if ($rose(LINE_TX_POS))
                pol_r <= 1'b1;
            else if ($rose(LINE_TX_NEG))
                pol_r <= 1'b0;
        end
    end

    // ==========================================
    // Assertions
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!NRST);
    AST_AMI_EXCL: assert property (!(LINE_TX_POS && LINE_TX_NEG))
        else $error("Both line polarities driven");
    AST_ALT_POS: assert property ($rose(LINE_TX_POS) && seen_r |-> !pol_r)
        else $error("Positive mark repeats polarity");
    AST_ALT_NEG: assert property ($rose(LINE_TX_NEG) && seen_r |-> pol_r)
        else $error("Negative mark repeats polarity");
    AST_MARK_LEN: assert property (hp_r <= SYM_CYC && hn_r <= SYM_CYC)
        else $error("Mark longer than one symbol");
    AST_PD_QUIET: assert property (pd_r > SYM_CYC + 2 |-> !LINE_TX_POS && !LINE_TX_NEG)
        else $error("Line driven while powered down");
    AST_OE_SEL: assert property (CTRL_SERIAL_OE == !CTRL_SEL_N)
        else $error("Serial output enable not tied to select");
    AST_SEL_IGNORE: assert property (CTRL_SEL_N && $past(CTRL_SEL_N) |-> $stable(POWERED_UP))
        else $error("Control changed with select high");
    AST_ALERT_CLR: assert property (rd1_r && !CTRL_SEL_N && $rose(CTRL_SHIFT_CLOCK) &&
        $stable(LOOP_SYNC) && $stable(LINE_SIGNAL_DETECTOR_N) |-> ##[1:3] !STATUS_ALERT_OE)
        else $error("Alert not cleared by status read");
    AST_ALERT_SET: assert property ($changed(LOOP_SYNC) |-> ##[0:2] STATUS_ALERT_OE)
        else $error("Alert not raised on sync change");
    AST_LSD_SEEN: assert property ($rose(LINE_RX_POS || LINE_RX_NEG) |-> ##[0:3] !LINE_SIGNAL_DETECTOR_N)
        else $error("Line pulse not detected");
    AST_RXV_SYNC: assert property (RX_VALID |-> LOOP_SYNC)
        else $error("Receive data without loop sync");
    AST_SYNC_PWR: assert property ($rose(LOOP_SYNC) |-> POWERED_UP)
        else $error("Sync gained while powered down");
    COV_SYNC_UP: cover property ($rose(LOOP_SYNC));
    COV_SYNC_DOWN: cover property ($fell(LOOP_SYNC));
    COV_WAKE: cover property ($fell(LINE_SIGNAL_DETECTOR_N) && !POWERED_UP);
endmodule // blc_core_assertions

bind blc_core blc_core_assertions #(.SYM_CYC(SYM_CYC)) chk_u (
    .CORE_CLK(CORE_CLK), .NRST(NRST), .CTRL_SHIFT_CLOCK(CTRL_SHIFT_CLOCK),
    .CTRL_SEL_N(CTRL_SEL_N), .CTRL_SERIAL_OE(CTRL_SERIAL_OE), .STATUS_ALERT_OE(STATUS_ALERT_OE),
    .LINE_TX_POS(LINE_TX_POS), .LINE_TX_NEG(LINE_TX_NEG), .LINE_RX_POS(LINE_RX_POS),
    .LINE_RX_NEG(LINE_RX_NEG), .LINE_SIGNAL_DETECTOR_N(LINE_SIGNAL_DETECTOR_N),
    .RX_VALID(RX_VALID), .POWERED_UP(POWERED_UP), .LOOP_SYNC(LOOP_SYNC));

// >>> sim/blc_peer.sv
// Far-end transceiver model answering each burst seen on the line
// Assumes symbol-level AMI pins and the core's symbol period
`timescale 1ns/10ps

module blc_peer #(
    parameter S = 8
) (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Line symbols
    input wire tx_pos,
    input wire tx_neg,
    output reg rx_pos,
    output reg rx_neg,
    // Behaviour
    input wire reply_en,
    input wire wake,
    output reg [15:0] zeros
);
    // ==========================================
    // Burst answer
    integer t;
    integer nb;
    reg on_r, snd_r, last_neg_r, b, s;
    reg [8:0] scr_r;
    reg [8:0] dsc_r;
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            t <= 0;
            nb <= 0;
            on_r <= 1'b0;
            snd_r <= 1'b0;
            last_neg_r <= 1'b1;
            scr_r <= 9'h000;
            dsc_r <= 9'h000;
            rx_pos <= 1'b0;
            rx_neg <= 1'b0;
            zeros <= 16'h0000;
        end
        else if (!on_r)
        begin
            on_r <= (tx_pos | tx_neg) | wake;
            snd_r <= (tx_pos | tx_neg) ? reply_en : 1'b1;
            t <= (tx_pos | tx_neg) ? 1 : 43 * S;
        end
        else
        begin
            t <= t + 1;
            // Descramble the far burst; the first bits only fill the history
            if (t > S && t < 37 * S && t % S == S / 2)
            begin
                b = tx_pos | tx_neg;
                dsc_r <= {dsc_r[7:0], b};
                nb <= nb + 1;
                if (nb > 20 && (b ^ dsc_r[8] ^ dsc_r[4]) == 1'b0)
                    zeros <= zeros + 16'h0001;
            end
            // Reply after 36 bits and 6 guard symbols
            if (snd_r && t >= 43 * S && t < 80 * S && t % S == 0)
            begin
                s = 1'b1;
                if (t != 43 * S)
                begin
                    s = 1'b1 ^ scr_r[8] ^ scr_r[4];
                    scr_r <= {scr_r[7:0], s};
                end
                rx_pos <= s & last_neg_r;
                rx_neg <= s & ~last_neg_r;
                if (s)
                    last_neg_r <= ~last_neg_r;
            end
            if (t >= 80 * S)
            begin
                on_r <= 1'b0;
                rx_pos <= 1'b0;
                rx_neg <= 1'b0;
            end
        end
    end
endmodule // blc_peer

// >>> sim/blc_core_tb.sv
// Testbench for the burst loop line codec core
// Assumes the peer model on the line and the bound port checker
`timescale 1ns/10ps

module blc_core_tb;
    // ==========================================
    // Stimulus and design
    reg core_clk = 1'b0;
    reg nrst = 1'b0;
    reg sclk = 1'b0;
    reg sel_n = 1'b1;
    reg sdi = 1'b0;
    reg frame_sync_a = 1'b0;
    reg burst_sync_input = 1'b0;
    reg fsa_en = 1'b1;
    reg mbs_en = 1'b0;
    reg tx_valid = 1'b0;
    reg tx_data = 1'b0;
    reg reply_en = 1'b1;
    reg wake = 1'b0;
    reg [7:0] rd;
    wire sdo, al_oe, tp, tn, rx_p, rx_n, lsd_n, tx_ready, rx_data, rx_valid, pup, sync;
    wire [15:0] zeros;
    integer cyc = 0, n = 0, rxn = 0, rxz = 0, mismatches = 0, checks_done = 0;
    always #2 core_clk = ~core_clk;
    blc_core #(.SYM_CYC(8), .BURST_CYC(2000), .ACQ_CYC(100), .SYNC_CYC(20000)) dut_u (
        .CORE_CLK(core_clk), .NRST(nrst), .CTRL_SHIFT_CLOCK(sclk), .CTRL_SEL_N(sel_n),
        .CTRL_SERIAL_IN(sdi), .CTRL_SERIAL_OUT(sdo), .CTRL_SERIAL_OE(),
        .STATUS_ALERT_N(), .STATUS_ALERT_OE(al_oe), .BURST_SYNC_INPUT(burst_sync_input),
        .FRAME_SYNC_A(frame_sync_a), .LINE_TX_POS(tp), .LINE_TX_NEG(tn), .LINE_RX_POS(rx_p),
        .LINE_RX_NEG(rx_n), .LINE_SIGNAL_DETECTOR_N(lsd_n), .TX_DATA(tx_data),
        .TX_VALID(tx_valid), .TX_READY(tx_ready), .RX_DATA(rx_data), .RX_VALID(rx_valid),
        .POWERED_UP(pup), .LOOP_SYNC(sync));
    blc_peer peer_u (.clk(core_clk), .rst_n(nrst), .tx_pos(tp), .tx_neg(tn),
        .rx_pos(rx_p), .rx_neg(rx_n), .reply_en(reply_en), .wake(wake), .zeros(zeros));

    // Frame sync gives a burst every 2000 cycles; burst sync runs at another phase
    always @(negedge core_clk)
    begin
        cyc <= cyc + 1;
        frame_sync_a <= fsa_en && (cyc % 1000 < 500);
        burst_sync_input <= mbs_en && ((cyc + 700) % 2000 < 100);
        rxn <= rxn + (rx_valid === 1'b1);
        rxz <= rxz + (rx_valid === 1'b1 && rx_data !== 1'b1);
    end

    // ==========================================
    // Tasks
    task chk(input [15:0] seen, input [15:0] exp);
        begin
            checks_done = checks_done + 1;
            if (seen !== exp)
            begin
                mismatches = mismatches + 1;
                $display("BAD %0t: got %h want %h", $time, seen, exp);
            end
        end
    endtask

    // One control transfer, MSB first; output sampled before each rise
    task xfer(input [7:0] wr, input integer nb, input selv);
        integer i;
        begin
            @(negedge core_clk);
            sel_n = selv;
            for (i = 0; i < nb; i = i + 1)
            begin
                sdi = wr[7 - i];
                repeat (3) @(negedge core_clk);
                rd[7 - i] = sdo;
                sclk = 1'b1;
                repeat (3) @(negedge core_clk);
                sclk = 1'b0;
            end
            repeat (3) @(negedge core_clk);
            sel_n = 1'b1;
            repeat (3) @(negedge core_clk);
        end
    endtask

    task tally_and_finish;
        begin
            $display("Checks %0d, mismatches %0d", checks_done, mismatches);
            if (mismatches == 0 && checks_done > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask

    // ==========================================
    // Tests
    initial
    begin
        #360000;
        mismatches = mismatches + 1;
        tally_and_finish;
    end

    initial
    begin
        repeat (12) @(negedge core_clk);
        nrst = 1'b1;
        @(negedge core_clk);
        chk({tp, tn, al_oe, pup, sync, lsd_n}, 16'h0001);
        tx_valid = 1'b1;
        for (n = 0; n < 40 && tx_ready === 1'b1; n = n + 1) @(negedge core_clk);
        tx_valid = 1'b0;
        chk(n, 16);
        xfer(8'h40, 7, 1'b0);
        chk(pup, 0);
        xfer(8'h40, 8, 1'b1);
        chk(pup, 0);
        xfer(8'h40, 8, 1'b0);
        chk(rd, 8'h00);
        chk(pup, 1);
        for (n = 0; n < 16000 && sync !== 1'b1; n = n + 1) @(negedge core_clk);
        chk(sync, 1);
        chk(zeros, 0);
        chk(al_oe, 1);
        mbs_en = 1'b1;
        repeat (6000) @(negedge core_clk);
        @(posedge burst_sync_input);
        for (n = 0; n < 20 && (tp | tn) !== 1'b1; n = n + 1) @(negedge core_clk);
        chk(n < 20, 1);
        // The 16 queued zeros leave in the first synced burst
        chk(zeros, 16);
        xfer(8'h40, 8, 1'b0);
        chk(rd, 8'h43);
        chk(al_oe, 0);
        chk(rxz, 0);
        chk(rxn > 0, 1);
        reply_en = 1'b0;
        repeat (5000) @(negedge core_clk);
        chk(sync, 1);
        for (n = 0; n < 5000 && sync !== 1'b0; n = n + 1) @(negedge core_clk);
        chk(sync, 0);
        xfer(8'h00, 8, 1'b0);
        chk(pup, 0);
        repeat (4500) @(negedge core_clk);
        chk(lsd_n, 1);
        wake = 1'b1;
        @(negedge core_clk);
        wake = 1'b0;
        for (n = 0; n < 800 && lsd_n !== 1'b0; n = n + 1) @(negedge core_clk);
        chk(lsd_n, 0);
        fsa_en = 1'b0;
        xfer(8'hc0, 8, 1'b0);
        xfer(8'hc0, 8, 1'b0);
        chk(rd[7:6], 2'b11);
        for (n = 0; n < 4200 && (tp | tn) !== 1'b1; n = n + 1) @(negedge core_clk);
        chk(n < 4200, 1);
        tally_and_finish;
    end
endmodule // blc_core_tb
